/* common/pmd_cfg.svh */
/*
 * Offsets, field positions, reset values and access codes of the
 * operating-mode block.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// =====================================================================
// Register offsets (byte addresses)
// =====================================================================
`define PMD_OFS_CTRL 12'h000
`define PMD_OFS_FPIMP 12'h004
`define PMD_OFS_STATE 12'h008
`define PMD_OFS_EVENT 12'h00C

// =====================================================================
// Control word fields
// =====================================================================
`define PMD_CTRL_DBG 0
`define PMD_CTRL_PRIV_LO 1
`define PMD_CTRL_PRIV_HI 2
`define PMD_CTRL_EXL 3
`define PMD_CTRL_ERL 4
`define PMD_CTRL_FRW 5
`define PMD_CTRL_UAC 6
`define PMD_CTRL_ISA 7

// =====================================================================
// Event word fields (write one to act)
// =====================================================================
`define PMD_EVT_EXC 0
`define PMD_EVT_ERR 1
`define PMD_EVT_RET 2

// =====================================================================
// State word fields
// =====================================================================
`define PMD_ST_MODE_LO 0
`define PMD_ST_MODE_HI 3
`define PMD_ST_SYSOK 4
`define PMD_ST_WIDEOK 5
`define PMD_ST_FP64 6
`define PMD_ST_ISA 7

// =====================================================================
// Privilege field codes and reset values
// =====================================================================
`define PMD_PRIV_KERNEL 2'h0
`define PMD_PRIV_SUPER 2'h1
`define PMD_PRIV_USER 2'h2
`define PMD_PRIV_RSVD 2'h3
`define PMD_RST_PRIV 2'h0
`define PMD_RST_EXL 1'h0
`define PMD_RST_ERL 1'h1

`endif

/* common/pmd_pkg.sv */
/*
 * Types of the operating-mode block.
 * Assumes the cfg header holds all numbers.
 */
package pmd_pkg;

  // ===================================================================
  // Operating modes, most privileged first
  // ===================================================================
  typedef enum logic [1:0] {
    PMD_DEBUG,
    PMD_KERNEL,
    PMD_SUPER,
    PMD_USER
  } pmd_mode_e;

  // ===================================================================
  // Compressed instruction-set variant built into the core
  // ===================================================================
  typedef enum logic [1:0] {
    PMD_CISA_NONE,
    PMD_CISA_COMPACT,
    PMD_CISA_ALT,
    PMD_CISA_VARLEN
  } pmd_cisa_e;

endpackage

/* hw/pmd_mode_ctrl.sv */
/*
 * Operating-mode control: mode state bits, APB register slave, derived
 * enables for system-control access, wide floating point, register
 * width model and instruction-set selection.
 * Assumes core event strobes are single-cycle pulses on clk_sys_in.
 */
// Local design decisions: the address map and register access over APB.
// Overview of operation
// - Debug-halt set gives debug mode with every kernel resource granted.
// - Debug clear: kernel if privilege field 00, exception or error flag.
// - Kernel at reset and whenever interrupt, exception or error is taken.
// - Kernel left only when all three kernel conditions false, e.g. return.
// - Supervisor when built, debug clear, field 01, both flags clear.
// - User when debug clear, field 10, both flags clear.
// - First-release 32-bit core never enables wide floating point.
// - Later releases: wide floating point legal only with capability flag.
// - Width flag 1: thirty-two 64-bit registers, any type.
// - Width flag 0: thirty-two 32-bit registers, wide values in pairs.
// - Fifth release on, floating point supports both width models.
// - System-control access in kernel, debug, or with user-access flag.
// - Selection bit 0 decodes standard, 1 the compressed encoding.
// - Selection bit saved into link target; register jump reloads it.
// - At most one compressed instruction-set variant is built.
// - Variable-length set behaves as selection bit stuck at 0.
`timescale 1ns/10ps
`include "pmd_cfg.svh"

module pmd_mode_ctrl #(
  parameter int RELEASE = 6,
  parameter bit IS_64BIT = 1'b0,
  parameter bit HAS_SUPER = 1'b1,
  parameter bit HAS_FPU = 1'b1,
  parameter bit WIDE_FP_CAP = 1'b1,
  parameter pmd_pkg::pmd_cisa_e CISA = pmd_pkg::PMD_CISA_COMPACT
) (
  input wire logic clk_sys_in, // Core clock, 100 MHz
  input wire logic srst_in, // Synchronous reset, high
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB write
  input wire logic [11:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error, unmapped address
  input wire logic exc_take_in, // Exception or interrupt taken
  input wire logic err_take_in, // Error taken
  input wire logic ret_in, // Exception return executes
  input wire logic jal_in, // Jump-and-link executes
  input wire logic jr_in, // Register jump executes
  input wire logic jr_src_isa_in, // Selection bit of jump source
  output pmd_pkg::pmd_mode_e mode_out, // Current mode
  output logic sysctrl_ok_out, // System-control access allowed
  output logic wide_fp_ok_out, // Wide floating point legal
  output logic fp64_regs_out, // 64-bit register model active
  output logic isa_sel_out, // 1: compressed decode
  output logic link_isa_out // Selection bit for link target
);

  // ===================================================================
  // Elaboration checks
  // ===================================================================
  if (RELEASE < 1 || RELEASE > 6) begin : g_bad_rel
    $error("RELEASE out of range");
  end
  if (CISA == pmd_pkg::PMD_CISA_VARLEN && RELEASE < 6) begin : g_bad_var
    $error("Variable-length set needs release 6");
  end

  localparam bit HAS_CISA = (CISA != pmd_pkg::PMD_CISA_NONE) &&
                            (CISA != pmd_pkg::PMD_CISA_VARLEN);
  localparam bit WIDE_ALLOWED = HAS_FPU && WIDE_FP_CAP &&
                                !(RELEASE == 1 && !IS_64BIT);
  localparam bit FR_WRITABLE = HAS_FPU && (RELEASE >= 5 || WIDE_ALLOWED);

  // ===================================================================
  // State bits
  // ===================================================================
  logic dbg;
  logic [1:0] priv;
  logic exception_level_flag;
  logic error_level_flag;
  logic frw;
  logic uac;
  logic isa;
  logic link_isa;
  logic [3:0] mode_oh;
  logic setup;
  logic wr_ctrl;
  logic wr_evt;
  logic hit;
  logic [31:0] ctrl_word;
  logic [31:0] state_word;
  logic [31:0] fpimp_word;
  logic exc_any;
  logic err_any;
  logic ret_any;
  logic [1:0] wpriv;
  logic priv_ok;

  // ===================================================================
  // APB decode
  // ===================================================================
  assign setup = psel_in && !penable_in;
  assign hit = (paddr_in == `PMD_OFS_CTRL) || (paddr_in == `PMD_OFS_FPIMP) ||
               (paddr_in == `PMD_OFS_STATE) || (paddr_in == `PMD_OFS_EVENT);
  assign wr_ctrl = psel_in && penable_in && pwrite_in && paddr_in == `PMD_OFS_CTRL;
  assign wr_evt = psel_in && penable_in && pwrite_in && paddr_in == `PMD_OFS_EVENT;
  assign pready_out = 1'b1;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pslverr_out <= 1'b0;
    end else if (setup) begin
      pslverr_out <= !hit;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      case (paddr_in)
        `PMD_OFS_CTRL: prdata_out <= ctrl_word;
        `PMD_OFS_FPIMP: prdata_out <= fpimp_word;
        `PMD_OFS_STATE: prdata_out <= state_word;
        default: prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ===================================================================
  // Kernel entry and exit events
  // ===================================================================
  assign exc_any = exc_take_in || (wr_evt && pwdata_in[`PMD_EVT_EXC]);
  assign err_any = err_take_in || (wr_evt && pwdata_in[`PMD_EVT_ERR]);
  assign ret_any = ret_in || (wr_evt && pwdata_in[`PMD_EVT_RET]);

  // Reset leaves the error flag set, so the core wakes in kernel mode
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      error_level_flag <= `PMD_RST_ERL;
    end else if (err_any) begin
      error_level_flag <= 1'b1;
    end else if (ret_any && error_level_flag) begin
      error_level_flag <= 1'b0;
    end else if (wr_ctrl) begin
      error_level_flag <= pwdata_in[`PMD_CTRL_ERL];
    end
  end

  // Return clears the error flag first, the exception flag only after
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      exception_level_flag <= `PMD_RST_EXL;
    end else if (exc_any) begin
      exception_level_flag <= 1'b1;
    end else if (ret_any && !error_level_flag) begin
      exception_level_flag <= 1'b0;
    end else if (wr_ctrl) begin
      exception_level_flag <= pwdata_in[`PMD_CTRL_EXL];
    end
  end

  // Reserved code, and supervisor code without supervisor, are refused
  assign wpriv = pwdata_in[`PMD_CTRL_PRIV_HI:`PMD_CTRL_PRIV_LO];
  assign priv_ok = (wpriv != `PMD_PRIV_RSVD) && (HAS_SUPER || wpriv != `PMD_PRIV_SUPER);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      priv <= `PMD_RST_PRIV;
    end else if (wr_ctrl && priv_ok) begin
      priv <= wpriv;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      dbg <= 1'b0;
      uac <= 1'b0;
    end else if (wr_ctrl) begin
      dbg <= pwdata_in[`PMD_CTRL_DBG];
      uac <= pwdata_in[`PMD_CTRL_UAC];
    end
  end

  // ===================================================================
  // Floating-point register width model
  // ===================================================================
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      frw <= 1'b0;
    end else if (wr_ctrl) begin
      frw <= FR_WRITABLE && pwdata_in[`PMD_CTRL_FRW];
    end
  end

  // ===================================================================
  // Instruction-set selection
  // ===================================================================
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      isa <= 1'b0;
    end else if (jr_in) begin
      isa <= HAS_CISA && jr_src_isa_in;
    end else if (wr_ctrl) begin
      isa <= HAS_CISA && pwdata_in[`PMD_CTRL_ISA];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      link_isa <= 1'b0;
    end else if (jal_in) begin
      link_isa <= isa;
    end
  end

  // ===================================================================
  // Mode decode and derived enables
  // ===================================================================
  pmd_mode_dec #(
    .HAS_SUPER(HAS_SUPER)
  ) u_dec (
    .dbg_in(dbg),
    .priv_in(priv),
    .exl_in(exception_level_flag),
    .erl_in(error_level_flag),
    .mode_out(mode_out),
    .onehot_out(mode_oh)
  );

  assign sysctrl_ok_out = mode_oh[0] || mode_oh[1] || uac;
  assign wide_fp_ok_out = WIDE_ALLOWED;
  assign fp64_regs_out = frw;
  assign isa_sel_out = isa;
  assign link_isa_out = link_isa;

  assign fpimp_word = {31'h0000_0000, WIDE_ALLOWED};
  assign ctrl_word = {24'h00_0000, isa, uac, frw, error_level_flag, exception_level_flag, priv, dbg};
  assign state_word = {24'h00_0000, isa, frw, WIDE_ALLOWED, sysctrl_ok_out, mode_oh};

  // ===================================================================
  // Checks
  // ===================================================================
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  // A control write in the same cycle may legally load the exception flag
  sequence s_ret_erl;
    ret_in && error_level_flag && !err_any && !exc_any && !wr_ctrl;
  endsequence

  sequence s_ret_exl;
    ret_in && !error_level_flag && exception_level_flag && !err_any && !exc_any;
  endsequence

  AST_DEBUG_FULL: assert property (
    dbg |-> mode_out == pmd_pkg::PMD_DEBUG && sysctrl_ok_out)
    else $error("Debug mode lacks full access");

  AST_KERNEL_COND: assert property (
    !dbg && (priv == `PMD_PRIV_KERNEL || exception_level_flag || error_level_flag) |-> mode_out == pmd_pkg::PMD_KERNEL)
    else $error("Kernel condition not decoded");

  AST_RESET_KERNEL: assert property (
    $past(srst_in) && !dbg |-> mode_out == pmd_pkg::PMD_KERNEL && error_level_flag)
    else $error("Not kernel after reset");

  AST_ENTRY_KERNEL: assert property (
    (exc_take_in || err_take_in) && !wr_ctrl |=> mode_oh[0] || mode_oh[1])
    else $error("Event did not enter kernel");

  AST_RET_ORDER: assert property (
    s_ret_erl |=> !error_level_flag && exception_level_flag == $past(exception_level_flag))
    else $error("Return cleared wrong flag");

  AST_RET_EXL: assert property (
    s_ret_exl ##1 (!wr_ctrl && !exc_any && !err_any)[*2] |-> !exception_level_flag && !error_level_flag)
    else $error("Return did not clear exception flag");

  AST_LEAVE_KERNEL: assert property (
    $past(mode_out) == pmd_pkg::PMD_KERNEL && mode_out != pmd_pkg::PMD_KERNEL
    && !dbg |-> !exception_level_flag && !error_level_flag && priv != `PMD_PRIV_KERNEL)
    else $error("Kernel left with condition true");

  AST_SUPER: assert property (
    !dbg && priv == `PMD_PRIV_SUPER && !exception_level_flag && !error_level_flag |->
    mode_out == (HAS_SUPER ? pmd_pkg::PMD_SUPER : pmd_pkg::PMD_USER))
    else $error("Supervisor decode wrong");

  AST_USER: assert property (
    !dbg && priv == `PMD_PRIV_USER && !exception_level_flag && !error_level_flag |-> mode_out == pmd_pkg::PMD_USER)
    else $error("User decode wrong");

  AST_WIDE_GATE: assert property (
    wide_fp_ok_out |-> fpimp_word[0] && !(RELEASE == 1 && !IS_64BIT))
    else $error("Wide floating point enabled illegally");

  AST_FR_WRITE: assert property (
    wr_ctrl |=> fp64_regs_out == (FR_WRITABLE && $past(pwdata_in[`PMD_CTRL_FRW])))
    else $error("Width flag write not honoured");

  AST_SYSCTRL: assert property (
    sysctrl_ok_out == (mode_out inside {pmd_pkg::PMD_DEBUG, pmd_pkg::PMD_KERNEL} || uac))
    else $error("System-control access wrong");

  AST_LINK_ISA: assert property (
    jal_in ##1 !jal_in |-> link_isa_out == $past(isa_sel_out, 1))
    else $error("Link selection bit not saved");

  AST_JR_ISA: assert property (
    jr_in |=> isa_sel_out == (HAS_CISA && $past(jr_src_isa_in)))
    else $error("Register jump selection bit wrong");

  AST_ONE_MODE: assert property (
    $onehot(mode_oh))
    else $error("Not exactly one mode active");

endmodule // pmd_mode_ctrl

/* hw/pmd_mode_dec.sv */
/*
 * Combinational operating-mode decoder.
 * Assumes control bits come from flip-flops on the core clock.
 */
`timescale 1ns/10ps
`include "pmd_cfg.svh"

module pmd_mode_dec #(
  parameter bit HAS_SUPER = 1'b1
) (
  input wire logic dbg_in, // Debug-halt flag
  input wire logic [1:0] priv_in, // Privilege-level field
  input wire logic exl_in, // Exception-level flag
  input wire logic erl_in, // Error-level flag
  output pmd_pkg::pmd_mode_e mode_out, // Decoded mode
  output logic [3:0] onehot_out // One bit per mode
);

  // ===================================================================
  // Priority decode: debug, kernel, supervisor, user
  // ===================================================================
  always_comb begin
    if (dbg_in) begin
      mode_out = pmd_pkg::PMD_DEBUG;
    end else if (priv_in == `PMD_PRIV_KERNEL || exl_in || erl_in) begin
      mode_out = pmd_pkg::PMD_KERNEL;
    end else if (HAS_SUPER && priv_in == `PMD_PRIV_SUPER) begin
      mode_out = pmd_pkg::PMD_SUPER;
    end else begin
      mode_out = pmd_pkg::PMD_USER;
    end
  end

  always_comb begin
    onehot_out = 4'h0;
    case (mode_out)
      pmd_pkg::PMD_DEBUG: onehot_out = 4'h1;
      pmd_pkg::PMD_KERNEL: onehot_out = 4'h2;
      pmd_pkg::PMD_SUPER: onehot_out = 4'h4;
      pmd_pkg::PMD_USER: onehot_out = 4'h8;
      default: onehot_out = 4'h0;
    endcase
  end

endmodule // pmd_mode_dec

/* tb/tb_privilege_mode_decode.sv */
/*
 * Self-checking bench for the operating-mode control block.
 * Assumes the cfg header and package are compiled first; no partner model.
 */
`timescale 1ns/10ps
`include "pmd_cfg.svh"

module tb_privilege_mode_decode;
  logic clk_sys_in, srst_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, exc_take_in, err_take_in, ret_in, jal_in, jr_in, jr_src_isa_in;
  pmd_pkg::pmd_mode_e mode_out;
  logic sysctrl_ok_out, wide_fp_ok_out, fp64_regs_out, isa_sel_out, link_isa_out;
  logic wide2, isa2, isa3;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;

  pmd_mode_ctrl DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .exc_take_in(exc_take_in), .err_take_in(err_take_in), .ret_in(ret_in), .jal_in(jal_in),
    .jr_in(jr_in), .jr_src_isa_in(jr_src_isa_in), .mode_out(mode_out),
    .sysctrl_ok_out(sysctrl_ok_out), .wide_fp_ok_out(wide_fp_ok_out),
    .fp64_regs_out(fp64_regs_out), .isa_sel_out(isa_sel_out), .link_isa_out(link_isa_out));

  // Second core: first release, 32-bit
  pmd_mode_ctrl #(.RELEASE(1)) DUT2 (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(), .pready_out(), .pslverr_out(),
    .exc_take_in(exc_take_in), .err_take_in(err_take_in), .ret_in(ret_in), .jal_in(jal_in),
    .jr_in(jr_in), .jr_src_isa_in(jr_src_isa_in), .mode_out(), .sysctrl_ok_out(),
    .wide_fp_ok_out(wide2), .fp64_regs_out(), .isa_sel_out(isa2), .link_isa_out());

  // Third core: sixth release, variable-length compressed set
  pmd_mode_ctrl #(.CISA(pmd_pkg::PMD_CISA_VARLEN)) DUT3 (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(), .pready_out(), .pslverr_out(),
    .exc_take_in(exc_take_in), .err_take_in(err_take_in), .ret_in(ret_in), .jal_in(jal_in),
    .jr_in(jr_in), .jr_src_isa_in(jr_src_isa_in), .mode_out(), .sysctrl_ok_out(),
    .wide_fp_ok_out(), .fp64_regs_out(), .isa_sel_out(isa3), .link_isa_out());

  // ===================================================================
  // Clock, timeout and shared tasks
  // ===================================================================
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Pulse {jr_src, jr, jal, ret, err, exc} for one cycle, then let it land
  task automatic ev(input logic [5:0] v);
    {jr_src_isa_in, jr_in, jal_in, ret_in, err_take_in, exc_take_in} <= v;
    @(posedge clk_sys_in);
    {jr_src_isa_in, jr_in, jal_in, ret_in, err_take_in, exc_take_in} <= 6'h00;
    @(posedge clk_sys_in);
  endtask

  function automatic logic [31:0] mk(logic d, logic [1:0] p, logic x, logic e, logic u);
    mk = 32'h0000_0000;
    mk[`PMD_CTRL_DBG] = d;
    mk[`PMD_CTRL_PRIV_HI:`PMD_CTRL_PRIV_LO] = p;
    mk[`PMD_CTRL_EXL] = x;
    mk[`PMD_CTRL_ERL] = e;
    mk[`PMD_CTRL_UAC] = u;
  endfunction

  task automatic set_ctrl(input logic [31:0] v);
    apb(1'b1, `PMD_OFS_CTRL, v);
    @(posedge clk_sys_in);
  endtask

  // ===================================================================
  // Scenarios
  // ===================================================================
  task automatic t_reset();
    chk("mode", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
    chk("sysok", 32'(sysctrl_ok_out), 32'h0000_0001);
    chk("ready", 32'(pready_out), 32'h0000_0001);
    apb(1'b0, `PMD_OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0001 << `PMD_CTRL_ERL);
  endtask

  task automatic t_modes();
    logic [31:0] c [8];
    pmd_pkg::pmd_mode_e m [8];
    logic s [8];
    c = '{mk(1, 2, 0, 0, 0), mk(0, 0, 0, 0, 0), mk(0, 1, 0, 0, 0), mk(0, 2, 0, 0, 0),
          mk(0, 2, 1, 0, 0), mk(0, 2, 0, 1, 0), mk(0, 2, 0, 0, 1), mk(0, 3, 0, 0, 0)};
    m = '{pmd_pkg::PMD_DEBUG, pmd_pkg::PMD_KERNEL, pmd_pkg::PMD_SUPER, pmd_pkg::PMD_USER,
          pmd_pkg::PMD_KERNEL, pmd_pkg::PMD_KERNEL, pmd_pkg::PMD_USER, pmd_pkg::PMD_USER};
    s = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      set_ctrl(c[i]);
      chk("mode", 32'(mode_out), 32'(m[i]));
      chk("sysok", 32'(sysctrl_ok_out), 32'(s[i]));
      apb(1'b0, `PMD_OFS_STATE, 32'h0000_0000);
      chk("state", rd & 32'h0000_001f, (32'(s[i]) << 4) | (32'h1 << m[i]));
    end
  endtask

  task automatic t_events();
    set_ctrl(mk(0, 2, 0, 0, 0));
    ev(6'h01);
    chk("mode exc", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
    ev(6'h04);
    chk("mode ret", 32'(mode_out), 32'(pmd_pkg::PMD_USER));
    ev(6'h03);
    chk("mode exc err", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
    ev(6'h04);
    chk("mode ret1", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
    apb(1'b0, `PMD_OFS_CTRL, 32'h0000_0000);
    chk("ctrl exl", rd, mk(0, 2, 1, 0, 0));
    ev(6'h04);
    chk("mode ret2", 32'(mode_out), 32'(pmd_pkg::PMD_USER));
    apb(1'b1, `PMD_OFS_EVENT, 32'h0000_0001 << `PMD_EVT_ERR);
    @(posedge clk_sys_in);
    chk("mode err reg", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
    apb(1'b1, `PMD_OFS_EVENT, 32'h0000_0001 << `PMD_EVT_RET);
    @(posedge clk_sys_in);
    chk("mode ret reg", 32'(mode_out), 32'(pmd_pkg::PMD_USER));
  endtask

  task automatic t_fp();
    chk("wide", 32'(wide_fp_ok_out), 32'h0000_0001);
    chk("wide r1", 32'(wide2), 32'h0000_0000);
    apb(1'b0, `PMD_OFS_FPIMP, 32'h0000_0000);
    chk("fpimp", rd, 32'h0000_0001);
    set_ctrl(32'h0000_0001 << `PMD_CTRL_FRW);
    chk("fp64", 32'(fp64_regs_out), 32'h0000_0001);
    // No floating-point instruction is issued, so width-0 hazards never arise
    set_ctrl(32'h0000_0000);
    chk("fp32", 32'(fp64_regs_out), 32'h0000_0000);
  endtask

  task automatic t_isa();
    set_ctrl(32'h0000_0001 << `PMD_CTRL_ISA);
    chk("isa", 32'(isa_sel_out), 32'h0000_0001);
    chk("isa varlen", 32'(isa3), 32'h0000_0000);
    chk("isa r1", 32'(isa2), 32'h0000_0001);
    ev(6'h08);
    chk("link", 32'(link_isa_out), 32'h0000_0001);
    ev(6'h10);
    chk("isa jr", 32'(isa_sel_out), 32'h0000_0000);
    ev(6'h08);
    chk("link0", 32'(link_isa_out), 32'h0000_0000);
    ev(6'h30);
    chk("isa jr1", 32'(isa_sel_out), 32'h0000_0001);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h010, mk(0, 2, 0, 0, 0));
    chk("err w", 32'(er), 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("err r", 32'(er), 32'h0000_0001);
    chk("data r", rd, 32'h0000_0000);
    @(posedge clk_sys_in);
    chk("mode kept", 32'(mode_out), 32'(pmd_pkg::PMD_KERNEL));
  endtask

  // ===================================================================
  // Main sequence
  // ===================================================================
  initial begin
    srst_in = 1'b1;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {jr_src_isa_in, jr_in, jal_in, ret_in, err_take_in, exc_take_in} = 6'h00;
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_modes();
    t_events();
    t_fp();
    t_isa();
    t_unmapped();
    wrap_up();
  end
endmodule // tb_privilege_mode_decode
